// *** pkg/serial_port_pkg.sv ***
package serial_port_pkg;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h0c;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h10;
    localparam logic [7:0] STATUS_RESET = 8'hc0;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam int OVERSAMPLE = 16;
    localparam int BASE_DIV = 2;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] LAST_TICK = 4'hf;

    typedef struct packed {
        logic txEmptyIrqEn;
        logic txDoneIrqEn;
        logic rxIrqEn;
        logic idleIrqEn;
        logic txEnable;
        logic rxEnable;
        logic rxMute;
        logic sendBreakCtl;
    } ctrl_two_t;

    typedef struct packed {
        logic [1:0] prescaleSel;
        logic [2:0] txRateSel;
        logic [2:0] rxRateSel;
    } rate_t;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_HUNT, RX_SHIFT} rx_state_t;
endpackage

// *** design/serial_port.sv ***
// Summary of operation
// RQ1 - bad stop or break sets framing error
// RQ2 - rx flags clear by status-then-data read
// RQ3 - bit rate clock over 32 prescale divisor
// RQ4 - prescale 1,3,4,13; divisors power of two
// RQ5 - software leaves rate register alone while enabled
// RQ6 - mute blocks rx flags and interrupts
// RQ7 - wake on idle or address mark
// RQ8 - idle wake clears mute, no idle flag
// RQ9 - address mark ends mute, word received
// RQ10 - tx empty sets on shift load
// RQ11 - tx done sets after frame ends
// RQ12 - rx full sets on readable word
// RQ13 - idle flag once per received word
// RQ14 - overrun keeps holding, flags error
// RQ15 - noise flag rises with rx full
// RQ16 - framing plus overrun sets overrun only
// RQ17 - word length selects 8 or 9 bits
// RQ18 - one interrupt from enabled flag sources
// RQ19 - tx enable owns pin; toggle sends preamble
// RQ20 - rx disable clears flags, enable hunts
// RQ21 - send break sends break frames
// RQ22 - prescale code mapping 1,3,4,13
// RQ23 - divisor code n gives two to n
// RQ24 - three-sample majority vote, noise report
module serial_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxPin,
    output logic txPin,
    output logic txPinOe,
    output logic serialIrq
);
    ////////////////////////////////////////////////////////////////
    logic wrAcc, rdAcc;
    logic [7:0] status, ctrlOne;
    serial_port_pkg::ctrl_two_t ctrl_ff;
    serial_port_pkg::rate_t rate_ff;
    logic ninthCfg_ff, wakeAddr_ff, txNinth_ff, rxNinth_ff;
    logic txEmpty_ff, txDone_ff, rxFull_ff, idle_ff, overrun_ff, noise_ff, frameErr_ff;
    logic statusSeen_ff, idleArmed_ff;
    logic [8:0] txHold_ff, rxHold_ff;
    logic txHoldFull_ff, preambleReq_ff, breakReq_ff;

    assign pready = 1'b1;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign pslverr = psel && penable && !(paddr == serial_port_pkg::OFS_STATUS || paddr == serial_port_pkg::OFS_DATA
        || paddr == serial_port_pkg::OFS_RATE || paddr == serial_port_pkg::OFS_CTRL_ONE
        || paddr == serial_port_pkg::OFS_CTRL_TWO);
    assign status = {txEmpty_ff, txDone_ff, rxFull_ff, idle_ff, overrun_ff, noise_ff, frameErr_ff, 1'b0};
    assign ctrlOne = {rxNinth_ff, txNinth_ff, 1'b0, ninthCfg_ff, wakeAddr_ff, 3'b000};

    logic dataRd, dataWr, seqRd, seqWr;
    assign dataRd = rdAcc && paddr == serial_port_pkg::OFS_DATA;
    assign dataWr = wrAcc && paddr == serial_port_pkg::OFS_DATA;
    assign seqRd = dataRd && statusSeen_ff; // RQ2
    assign seqWr = dataWr && statusSeen_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                serial_port_pkg::OFS_STATUS: prdata <= {24'h00_0000, status};
                serial_port_pkg::OFS_DATA: prdata <= {24'h00_0000, rxHold_ff[7:0]};
                serial_port_pkg::OFS_RATE: prdata <= {24'h00_0000, rate_ff};
                serial_port_pkg::OFS_CTRL_ONE: prdata <= {24'h00_0000, ctrlOne};
                serial_port_pkg::OFS_CTRL_TWO: prdata <= {24'h00_0000, ctrl_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // status access arms the clearing sequence
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            statusSeen_ff <= 1'b0;
        end else if (psel && penable && paddr == serial_port_pkg::OFS_STATUS) begin
            statusSeen_ff <= 1'b1;
        end else if (dataRd || dataWr) begin
            statusSeen_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic wakeIdle, wakeAddr;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= serial_port_pkg::CTRL_TWO_RESET;
            rate_ff <= serial_port_pkg::RATE_RESET;
            ninthCfg_ff <= 1'b0;
            wakeAddr_ff <= 1'b0;
            txNinth_ff <= 1'b0;
        end else begin
            if (wrAcc && paddr == serial_port_pkg::OFS_CTRL_TWO) begin
                ctrl_ff <= pwdata[7:0];
            end else if (wakeIdle || wakeAddr) begin
                ctrl_ff.rxMute <= 1'b0; // RQ6 RQ8 RQ9
            end
            if (wrAcc && paddr == serial_port_pkg::OFS_RATE) begin
                rate_ff <= pwdata[7:0]; // RQ5
            end
            if (wrAcc && paddr == serial_port_pkg::OFS_CTRL_ONE) begin
                txNinth_ff <= pwdata[6];
                ninthCfg_ff <= pwdata[4];
                wakeAddr_ff <= pwdata[3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // RQ3 RQ4 RQ22 RQ23: tick at 16x bit rate, base 2 gives 32
    logic [4:0] prescaleMax;
    always_comb begin
        case (rate_ff.prescaleSel)
            2'b00: prescaleMax = 5'd1;
            2'b01: prescaleMax = 5'd3;
            2'b10: prescaleMax = 5'd4;
            default: prescaleMax = 5'd13;
        endcase
    end
    logic [5:0] preCnt_ff;
    logic preTick;
    assign preTick = preCnt_ff == 6'(serial_port_pkg::BASE_DIV) * 6'(prescaleMax) - 6'd1;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_ff <= 6'd0;
        end else begin
            preCnt_ff <= preTick ? 6'd0 : preCnt_ff + 6'd1;
        end
    end
    logic [6:0] txDivCnt_ff, rxDivCnt_ff;
    logic txTick, rxTick;
    assign txTick = preTick && txDivCnt_ff == 7'((8'd1 << rate_ff.txRateSel) - 8'd1); // RQ23
    assign rxTick = preTick && rxDivCnt_ff == 7'((8'd1 << rate_ff.rxRateSel) - 8'd1);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txDivCnt_ff <= 7'd0;
            rxDivCnt_ff <= 7'd0;
        end else if (preTick) begin
            txDivCnt_ff <= txTick ? 7'd0 : txDivCnt_ff + 7'd1;
            rxDivCnt_ff <= rxTick ? 7'd0 : rxDivCnt_ff + 7'd1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmitter: shift frame of start, 8/9 data, stop
    serial_port_pkg::tx_state_t txState_ff;
    logic [10:0] txShift_ff;
    logic [3:0] txBits_ff, txPhase_ff;
    logic txLoad, txFrameEnd, txEnPrev_ff, breakPrev_ff;
    logic [3:0] frameBits;
    assign frameBits = ninthCfg_ff ? 4'd11 : 4'd10; // RQ17
    assign txFrameEnd = txState_ff == serial_port_pkg::TX_SHIFT && txTick
        && txPhase_ff == serial_port_pkg::LAST_TICK && txBits_ff == frameBits - 4'd1;
    assign txLoad = ctrl_ff.txEnable && txHoldFull_ff && !preambleReq_ff && !breakReq_ff
        && !ctrl_ff.sendBreakCtl && (txState_ff == serial_port_pkg::TX_IDLE || txFrameEnd);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txEnPrev_ff <= 1'b0;
            breakPrev_ff <= 1'b0;
            preambleReq_ff <= 1'b0;
            breakReq_ff <= 1'b0;
        end else begin
            txEnPrev_ff <= ctrl_ff.txEnable;
            breakPrev_ff <= ctrl_ff.sendBreakCtl;
            if (ctrl_ff.txEnable && !txEnPrev_ff) begin
                preambleReq_ff <= 1'b1; // RQ19
            end else if (txState_ff == serial_port_pkg::TX_IDLE && preambleReq_ff) begin
                preambleReq_ff <= 1'b0;
            end
            if (breakPrev_ff && !ctrl_ff.sendBreakCtl) begin
                breakReq_ff <= 1'b1; // RQ21
            end else if (txState_ff == serial_port_pkg::TX_IDLE && breakReq_ff) begin
                breakReq_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txState_ff <= serial_port_pkg::TX_IDLE;
            txShift_ff <= 11'h7ff;
            txBits_ff <= 4'd0;
            txPhase_ff <= 4'd0;
        end else if (!ctrl_ff.txEnable && txState_ff == serial_port_pkg::TX_IDLE) begin
            txState_ff <= serial_port_pkg::TX_IDLE;
            txShift_ff <= 11'h7ff;
        end else if (txLoad) begin
            txState_ff <= serial_port_pkg::TX_SHIFT;
            txShift_ff <= ninthCfg_ff ? {1'b1, txHold_ff, 1'b0} : {2'b11, txHold_ff[7:0], 1'b0};
            txBits_ff <= 4'd0;
            txPhase_ff <= 4'd0;
        end else begin
            case (txState_ff)
                serial_port_pkg::TX_IDLE: begin
                    if (ctrl_ff.sendBreakCtl || breakReq_ff) begin
                        // break frame: all zeros; the idle branch raises the line once breaks stop
                        txState_ff <= serial_port_pkg::TX_SHIFT; // RQ21
                        txShift_ff <= 11'h000;
                        txBits_ff <= 4'd0;
                        txPhase_ff <= 4'd0;
                    end else if (preambleReq_ff) begin
                        txState_ff <= serial_port_pkg::TX_SHIFT; // RQ19
                        txShift_ff <= 11'h7ff;
                        txBits_ff <= 4'd0;
                        txPhase_ff <= 4'd0;
                    end else begin
                        txShift_ff <= 11'h7ff;
                    end
                end
                serial_port_pkg::TX_SHIFT: begin
                    if (txTick) begin
                        txPhase_ff <= txPhase_ff + 4'd1;
                        if (txPhase_ff == serial_port_pkg::LAST_TICK) begin
                            txShift_ff <= {1'b1, txShift_ff[10:1]};
                            txBits_ff <= txBits_ff + 4'd1;
                            if (txFrameEnd) begin
                                txState_ff <= serial_port_pkg::TX_IDLE;
                            end
                        end
                    end
                end
                default: txState_ff <= serial_port_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txHold_ff <= 9'h000;
            txHoldFull_ff <= 1'b0;
            txEmpty_ff <= 1'b1;
            txDone_ff <= 1'b1;
            txPin <= 1'b1;
            txPinOe <= 1'b0;
        end else begin
            txPin <= txShift_ff[0];
            txPinOe <= ctrl_ff.txEnable; // RQ19
            if (dataWr) begin
                txHold_ff <= {txNinth_ff, pwdata[7:0]}; // RQ17
            end
            if (!ctrl_ff.txEnable) begin
                txHoldFull_ff <= 1'b0;
            end else if (dataWr) begin
                txHoldFull_ff <= 1'b1;
            end else if (txLoad) begin
                txHoldFull_ff <= 1'b0;
            end
            if (txLoad) begin
                txEmpty_ff <= 1'b1; // RQ10
            end else if (seqWr) begin
                txEmpty_ff <= 1'b0;
            end
            if (txFrameEnd) begin
                txDone_ff <= 1'b1; // RQ11
            end else if (seqWr) begin
                txDone_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // receiver
    logic rxS1_ff, rxS2_ff, rxS3_ff, rxLine_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxS1_ff <= 1'b1;
            rxS2_ff <= 1'b1;
            rxS3_ff <= 1'b1;
            rxLine_ff <= 1'b1;
        end else begin
            rxS1_ff <= rxPin;
            rxS2_ff <= rxS1_ff;
            rxS3_ff <= rxS2_ff;
            if (rxS2_ff == rxS3_ff) begin
                rxLine_ff <= rxS3_ff;
            end
        end
    end

    serial_port_pkg::rx_state_t rxState_ff;
    logic [3:0] rxPhase_ff, rxBits_ff, idleCnt_ff;
    logic [1:0] votes_ff;
    logic [9:0] rxShift_ff;
    logic rxNoise_ff, bitVal, bitNoisy, rxDone, idleSeen;
    logic [1:0] voteSum;
    assign voteSum = votes_ff + {1'b0, rxLine_ff};
    assign bitVal = voteSum >= 2'd2; // RQ24
    assign bitNoisy = voteSum != 2'd0 && voteSum != 2'd3;
    assign rxDone = rxState_ff == serial_port_pkg::RX_SHIFT && rxTick
        && rxPhase_ff == serial_port_pkg::SAMPLE_C && rxBits_ff == frameBits - 4'd1;
    // full frame time of ones on the line
    assign idleSeen = rxState_ff == serial_port_pkg::RX_HUNT && rxTick
        && rxPhase_ff == serial_port_pkg::LAST_TICK && idleCnt_ff == frameBits - 4'd1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxState_ff <= serial_port_pkg::RX_HUNT;
            rxPhase_ff <= 4'd0;
            rxBits_ff <= 4'd0;
            idleCnt_ff <= 4'd0;
            votes_ff <= 2'd0;
            rxShift_ff <= 10'h000;
            rxNoise_ff <= 1'b0;
        end else if (!ctrl_ff.rxEnable) begin
            rxState_ff <= serial_port_pkg::RX_HUNT; // RQ20
            rxPhase_ff <= 4'd0;
            idleCnt_ff <= 4'd0;
        end else if (rxTick) begin
            case (rxState_ff)
                serial_port_pkg::RX_HUNT: begin
                    if (!rxLine_ff) begin
                        rxState_ff <= serial_port_pkg::RX_SHIFT;
                        rxPhase_ff <= 4'd1;
                        rxBits_ff <= 4'd0;
                        idleCnt_ff <= 4'd0;
                        rxNoise_ff <= 1'b0;
                        votes_ff <= 2'd0;
                    end else begin
                        rxPhase_ff <= rxPhase_ff + 4'd1;
                        if (rxPhase_ff == serial_port_pkg::LAST_TICK && idleCnt_ff != frameBits) begin
                            idleCnt_ff <= idleCnt_ff + 4'd1;
                        end
                    end
                end
                serial_port_pkg::RX_SHIFT: begin
                    rxPhase_ff <= rxPhase_ff + 4'd1;
                    if (rxPhase_ff == serial_port_pkg::SAMPLE_A || rxPhase_ff == serial_port_pkg::SAMPLE_B) begin
                        votes_ff <= votes_ff + {1'b0, rxLine_ff};
                    end
                    if (rxPhase_ff == serial_port_pkg::SAMPLE_C) begin
                        votes_ff <= 2'd0;
                        rxShift_ff <= {bitVal, rxShift_ff[9:1]};
                        rxNoise_ff <= rxNoise_ff | bitNoisy; // RQ24
                        rxBits_ff <= rxBits_ff + 4'd1;
                        if (rxBits_ff == 4'd0 && bitVal) begin
                            rxState_ff <= serial_port_pkg::RX_HUNT;
                            rxPhase_ff <= 4'd0;
                        end else if (rxDone) begin
                            rxState_ff <= serial_port_pkg::RX_HUNT;
                            rxPhase_ff <= 4'd0;
                        end
                    end
                end
                default: rxState_ff <= serial_port_pkg::RX_HUNT;
            endcase
        end
    end

    // word fields while the final stop sample is voted, before it shifts in
    logic [8:0] rxWord;
    logic rxStop, rxMsb, rxNoiseNow;
    assign rxStop = bitVal;
    assign rxWord = ninthCfg_ff ? rxShift_ff[9:1] : {1'b0, rxShift_ff[9:2]};
    assign rxMsb = ninthCfg_ff ? rxShift_ff[9] : rxShift_ff[9];
    assign rxNoiseNow = rxNoise_ff | bitNoisy;
    assign wakeIdle = ctrl_ff.rxMute && !wakeAddr_ff && idleSeen; // RQ7 RQ8
    assign wakeAddr = ctrl_ff.rxMute && wakeAddr_ff && rxDone && rxMsb; // RQ7 RQ9

    logic rxAccept, rxClr;
    assign rxAccept = rxDone && (!ctrl_ff.rxMute || wakeAddr); // RQ6 RQ9
    assign rxClr = seqRd;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxHold_ff <= 9'h000;
            rxNinth_ff <= 1'b0;
            rxFull_ff <= 1'b0;
            idle_ff <= 1'b0;
            overrun_ff <= 1'b0;
            noise_ff <= 1'b0;
            frameErr_ff <= 1'b0;
            idleArmed_ff <= 1'b1;
        end else if (!ctrl_ff.rxEnable) begin
            rxFull_ff <= 1'b0; // RQ20 RQ2
            idle_ff <= 1'b0;
            overrun_ff <= 1'b0;
            noise_ff <= 1'b0;
            frameErr_ff <= 1'b0;
            idleArmed_ff <= 1'b1;
        end else begin
            if (rxAccept && rxFull_ff) begin
                overrun_ff <= 1'b1; // RQ14 RQ16
            end else if (rxClr) begin
                overrun_ff <= 1'b0;
            end
            if (rxAccept && !rxFull_ff) begin
                rxHold_ff <= rxWord; // RQ12
                rxNinth_ff <= rxWord[8]; // RQ17
                rxFull_ff <= 1'b1;
                noise_ff <= rxNoiseNow; // RQ15
                frameErr_ff <= !rxStop; // RQ1
                idleArmed_ff <= 1'b1; // RQ13
            end else if (rxClr) begin
                rxFull_ff <= 1'b0;
                noise_ff <= 1'b0;
                frameErr_ff <= 1'b0;
            end
            if (idleSeen && !ctrl_ff.rxMute && idleArmed_ff) begin
                idle_ff <= 1'b1; // RQ13
                idleArmed_ff <= 1'b0;
            end else if (rxClr) begin
                idle_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // RQ18 RQ6: receive sources masked while muted
    assign serialIrq = (txEmpty_ff && ctrl_ff.txEmptyIrqEn) || (txDone_ff && ctrl_ff.txDoneIrqEn)
        || (!ctrl_ff.rxMute && ctrl_ff.rxIrqEn && (rxFull_ff || overrun_ff))
        || (!ctrl_ff.rxMute && ctrl_ff.idleIrqEn && idle_ff);
endmodule // serial_port

// *** tb/serial_port_asserts.sv ***
module serial_port_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxPin,
    input wire logic txPin,
    input wire logic txPinOe,
    input wire logic serialIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic mapped;
    assign mapped = paddr inside {serial_port_pkg::OFS_STATUS, serial_port_pkg::OFS_DATA,
        serial_port_pkg::OFS_RATE, serial_port_pkg::OFS_CTRL_ONE, serial_port_pkg::OFS_CTRL_TWO};
    ////////////////////////////////////////
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_ctl2_write;
        psel && penable && pwrite && paddr == serial_port_pkg::OFS_CTRL_TWO;
    endsequence
    ////////////////////////////////////////
    a_ready_no_wait: assert property (s_access |-> pready)
        else $error("pready low in an access phase");
    a_unmapped_refused: assert property (s_access ##0 !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (s_access ##0 mapped |-> !pslverr)
        else $error("error on a mapped access");
    a_status_reserved: assert property (s_access ##0 (!pwrite && paddr == serial_port_pkg::OFS_STATUS)
        |-> prdata[0] == 1'b0 && prdata[31:8] == 24'h00_0000)
        else $error("status reserved bits not zero");
    a_prdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");
    a_oe_follows_te: assert property (s_ctl2_write |=> ##1 txPinOe == $past(pwdata[3], 2))
        else $error("pin enable does not follow tx enable");
    a_irq_masked: assert property (s_ctl2_write ##0 pwdata[7:4] == 4'h0 |=> ##1 !serialIrq)
        else $error("interrupt with all enables off");
    a_rx_off_clears: assert property (s_ctl2_write ##0 !pwdata[2] ##2 (psel && !penable && !pwrite
        && paddr == serial_port_pkg::OFS_STATUS) |=> prdata[5:1] == 5'h00)
        else $error("rx flags survive rx disable");
    a_start_width: assert property ($fell(txPin) && txPinOe |-> !txPin [*8])
        else $error("start bit too short");
    a_bit_stable: assert property (disable iff (sys_rst || !txPinOe)
        $changed(txPin) && $past(txPinOe) |=> $stable(txPin) [*7])
        else $error("tx bit shorter than minimum");
endmodule // serial_port_asserts

bind serial_port serial_port_asserts serial_port_asserts_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .txPinOe(txPinOe), .serialIrq(serialIrq));

// *** tb/remote_serial.sv ***
module remote_serial (
    input wire logic clk,
    input wire logic lineIn,
    output logic lineOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int w;
    int lastWidth = 0;
    int frameCount = 0;
    logic [7:0] lastWord = 8'h00;
    initial lineOut = 1'b1;
    ////////////////////////////////////////
    task automatic sendWord(input logic [8:0] d, input int nbits, input logic stopVal, input int bitCyc);
        for (int i = 0; i < nbits + 2; i++) begin
            @(posedge clk);
            lineOut <= (i == 0) ? 1'b0 : (i <= nbits) ? d[i - 1] : stopVal;
            repeat (bitCyc - 1) @(posedge clk);
        end
        @(posedge clk);
        lineOut <= 1'b1;
    endtask
    ////////////////////////////////////////
    // start bit length sets the sampling grid, so any bit time up to 20000 cycles is followed
    initial forever begin
        @(posedge clk iff lineIn === 1'b0);
        w = 0;
        while (lineIn === 1'b0 && w < 20000) begin
            @(posedge clk);
            w++;
        end
        repeat (w / 2 - 1) @(posedge clk);
        lastWord[0] = lineIn;
        for (int i = 1; i < 8; i++) begin
            repeat (w) @(posedge clk);
            lastWord[i] = lineIn;
        end
        repeat (w) @(posedge clk);
        wait (lineIn === 1'b1);
        lastWidth = w;
        frameCount++;
    end
endmodule // remote_serial

// *** tb/serial_port_test.sv ***
module serial_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 32;
    localparam logic [7:0] ST = serial_port_pkg::OFS_STATUS;
    localparam logic [7:0] DT = serial_port_pkg::OFS_DATA;
    localparam logic [7:0] RT = serial_port_pkg::OFS_RATE;
    localparam logic [7:0] C1 = serial_port_pkg::OFS_CTRL_ONE;
    localparam logic [7:0] C2 = serial_port_pkg::OFS_CTRL_TWO;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, rxPin, txPin, txPinOe, serialIrq;
    int failures = 0;
    int checksDone = 0;
    int n, c;
    logic [7:0] rates [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h18};
    int widths [5] = '{32, 96, 128, 416, 256};
    serial_port serial_port_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxPin(rxPin), .txPin(txPin), .txPinOe(txPinOe), .serialIrq(serialIrq));
    remote_serial remote_serial_i (.clk(clk), .lineIn(txPin), .lineOut(rxPin));
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(nm, q, {24'h00_0000, exp});
    endtask
    task automatic irqChk(input logic e);
        @(negedge clk);
        check("irq", 32'(serialIrq), 32'(e));
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        conclude();
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk("status", ST, 8'hc0);
        rdChk("ctrl two", C2, 8'h00);
        rdChk("unmapped", 8'h14, 8'h00);
        wr(C2, 32'h0000_0024);
        remote_serial_i.sendWord(9'h0a5, 8, 1'b1, BIT);
        rdChk("status", ST, 8'he0);
        irqChk(1'b1);
        rdChk("data", DT, 8'ha5);
        rdChk("status", ST, 8'hc0);
        remote_serial_i.sendWord(9'h03c, 8, 1'b0, BIT);
        rdChk("status", ST, 8'he2);
        wr(C2, 32'h0000_0000);
        rdChk("status", ST, 8'hc0);
        wr(C2, 32'h0000_0004);
        remote_serial_i.sendWord(9'h011, 8, 1'b1, BIT);
        remote_serial_i.sendWord(9'h022, 8, 1'b0, BIT);
        rdChk("status", ST, 8'he8);
        rdChk("data", DT, 8'h11);
        wr(C2, 32'h0000_0000);
        wr(C1, 32'h0000_0010);
        wr(C2, 32'h0000_0004);
        remote_serial_i.sendWord(9'h15a, 9, 1'b1, BIT);
        rdChk("data", DT, 8'h5a);
        rdChk("ctrl one", C1, 8'h90);
        wr(C2, 32'h0000_0000);
        wr(C1, 32'h0000_0008);
        wr(C2, 32'h0000_0006);
        remote_serial_i.sendWord(9'h012, 8, 1'b1, BIT);
        rdChk("status", ST, 8'hc0);
        remote_serial_i.sendWord(9'h085, 8, 1'b1, BIT);
        rdChk("status", ST, 8'he0);
        rdChk("ctrl two", C2, 8'h04);
        rdChk("data", DT, 8'h85);
        wr(C2, 32'h0000_0000);
        wr(C1, 32'h0000_0000);
        wr(C2, 32'h0000_0006);
        repeat (12 * BIT) @(posedge clk);
        rdChk("ctrl two", C2, 8'h04);
        rdChk("status", ST, 8'hc0);
        wr(C2, 32'h0000_0000);
        wr(C2, 32'h0000_0014);
        repeat (12 * BIT) @(posedge clk);
        rdChk("status", ST, 8'hd0);
        irqChk(1'b1);
        xfer(1'b0, DT, 32'h0000_0000);
        repeat (12 * BIT) @(posedge clk);
        rdChk("status", ST, 8'hc0);
        for (int k = 0; k < 5; k++) begin
            wr(C2, 32'h0000_0000);
            wr(RT, {24'h00_0000, rates[k]});
            wr(C2, 32'h0000_0008);
            xfer(1'b0, ST, 32'h0000_0000);
            wr(DT, 32'h0000_0055);
            if (k == 0) rdChk("status", ST, 8'h00);
            c = remote_serial_i.frameCount;
            for (n = 0; n < 20000 && remote_serial_i.frameCount == c; n++) @(posedge clk);
            check("bit width", remote_serial_i.lastWidth, widths[k]);
            check("tx word", {24'h00_0000, remote_serial_i.lastWord}, 32'h0000_0055);
            if (k == 0) rdChk("status", ST, 8'hc0);
        end
        wr(C2, 32'h0000_0000);
        wr(RT, 32'h0000_0000);
        wr(C2, 32'h0000_0009);
        repeat (25 * BIT) @(negedge clk);
        check("break line", 32'(txPin), 32'h0000_0000);
        wr(C2, 32'h0000_0048);
        repeat (30 * BIT) @(negedge clk);
        check("idle line", 32'(txPin), 32'h0000_0001);
        irqChk(1'b1);
        conclude();
    end
endmodule // serial_port_test
